// *** src/t8c_pkg.sv ***
// Purpose: shared constants and helpers of the 8-bit timer compare block
// Assumes: byte-wide register port, 4-bit register address
// Notes:   all offsets, fields, codes and reset values live here
package t8c_pkg;
	// register offsets
	localparam logic [3:0] T8C_OFS_CTRL  = 4'h0;
	localparam logic [3:0] T8C_OFS_CLK   = 4'h1;
	localparam logic [3:0] T8C_OFS_COUNT = 4'h2;
	localparam logic [3:0] T8C_OFS_CMPA  = 4'h3;
	localparam logic [3:0] T8C_OFS_CMPB  = 4'h4;
	localparam logic [3:0] T8C_OFS_FLAGS = 4'h5;
	localparam logic [3:0] T8C_OFS_IRQEN = 4'h6;
	// field positions
	localparam int T8C_MODE_LSB  = 0;
	localparam int T8C_ACTA_LSB  = 4;
	localparam int T8C_ACTB_LSB  = 6;
	localparam int T8C_CSEL_LSB  = 0;
	localparam int T8C_FRCA_BIT  = 6;
	localparam int T8C_FRCB_BIT  = 7;
	localparam int T8C_FLG_OVF   = 0;
	localparam int T8C_FLG_A     = 1;
	localparam int T8C_FLG_B     = 2;
	// waveform modes, clock stop select code and output actions
	localparam logic [2:0] T8C_MODE_NORMAL         = 3'h0;
	localparam logic [2:0] T8C_MODE_CLEAR_ON_MATCH = 3'h2;
	localparam logic [2:0] T8C_CLK_STOP            = 3'h0;
	localparam logic [1:0] T8C_ACT_NONE            = 2'h0;
	localparam logic [1:0] T8C_ACT_TOGGLE          = 2'h1;
	localparam logic [1:0] T8C_ACT_CLEAR           = 2'h2;
	localparam logic [1:0] T8C_ACT_SET             = 2'h3;
	// counter limits and reset values
	localparam logic [7:0] T8C_COUNT_MAX    = 8'hff;
	localparam logic [7:0] T8C_COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] T8C_RST_BYTE     = 8'h00;
	localparam logic       T8C_RST_LATCH    = 1'b0;

	// odd waveform modes are the pwm modes
	function automatic logic t8c_is_pwm(input logic [2:0] mode);
		return mode[0];
	endfunction
endpackage

// *** src/t8c_unit_if.sv ***
// Purpose: bundle between the timer core and one compare unit
// Assumes: single clock domain
// Notes:   ctl drives the unit, unit answers with match and latch
`timescale 1ns/1ps
interface t8c_unit_if;
	logic [7:0] count;
	logic       tick;
	logic       block;
	logic       pwm;
	logic       frc;
	logic [1:0] action;
	logic       wr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       eq;
	logic       hit;
	logic       latch;
	modport unit (input count, tick, block, pwm, frc, action, wr, wdata,
		output rdata, eq, hit, latch);
	modport ctl (output count, tick, block, pwm, frc, action, wr, wdata,
		input rdata, eq, hit, latch);
endinterface

// *** src/t8c_cmp_unit.sv ***
// Purpose: one compare unit: compare value, buffer and output latch
// Assumes: tick is the gated timer clock enable
// Notes:   buffer only steers the active value in pwm modes
`timescale 1ns/1ps
module t8c_cmp_unit
	import t8c_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// core side
	t8c_unit_if.unit u
);
	typedef struct packed {
		logic [7:0] active;
		logic [7:0] buffer;
		logic       latch;
	} t8c_unit_s;
	t8c_unit_s st;
	t8c_unit_s next_st;

	// match detection and register access
	assign u.eq    = (u.count == st.active); // RQ1
	assign u.hit   = u.tick && u.eq && !u.block; // RQ7
	assign u.rdata = u.pwm ? st.buffer : st.active; // RQ5
	assign u.latch = st.latch;

	// next state of the unit
	always_comb
	begin
		next_st = st;
		if (u.wr)
		begin
			next_st.buffer = u.wdata; // RQ5
			if (!u.pwm)
				next_st.active = u.wdata; // RQ4
		end
		// pwm update at bottom keeps pulses whole
		if (u.pwm && u.tick && u.count == T8C_COUNT_BOTTOM)
			next_st.active = st.buffer; // RQ4
		// outside pwm modes a forced or real match drives the latch, action read live
		if (!u.pwm && (u.hit || u.frc)) // RQ6 RQ9
		begin
			case (u.action)
				T8C_ACT_TOGGLE: next_st.latch = !st.latch; // RQ20
				T8C_ACT_CLEAR:  next_st.latch = 1'b0;
				T8C_ACT_SET:    next_st.latch = 1'b1;
				default:        next_st.latch = st.latch; // RQ12
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			st <= '{T8C_RST_BYTE, T8C_RST_BYTE, T8C_RST_LATCH}; // RQ10
		else
			st <= next_st;
	end
endmodule

// *** src/t8c_counter.sv ***
// Purpose: 8-bit up counter with write override and match blocking
// Assumes: tick already gated by the clock source selection
// Notes:   block lasts until the next timer tick after a write
`timescale 1ns/1ps
module t8c_counter
	import t8c_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// control
	input  wire logic       tick_i,
	input  wire logic       clear_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	// state
	output logic      [7:0] count_o,
	output logic            block_o,
	output logic            wrap_o
);
	typedef struct packed {
		logic [7:0] count;
		logic       block;
	} t8c_cnt_s;
	t8c_cnt_s st;
	t8c_cnt_s next_st;

	assign count_o = st.count;
	assign block_o = st.block;
	// max to bottom on a tick, a clear at max counts too
	assign wrap_o  = tick_i && !wr_i && st.count == T8C_COUNT_MAX; // RQ15 RQ21

	// count, clear or take the written value
	always_comb
	begin
		next_st = st;
		if (tick_i)
		begin
			next_st.block = 1'b0;
			next_st.count = clear_i ? T8C_COUNT_BOTTOM : 8'(st.count + 8'h01); // RQ14 RQ17
		end
		if (wr_i)
		begin
			next_st.count = wdata_i; // RQ24
			next_st.block = 1'b1; // RQ7
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			st <= '{T8C_RST_BYTE, 1'b0};
		else
			st <= next_st;
	end
endmodule

// *** src/t8c_timer.sv ***
// Purpose: compare part of an 8-bit timer, normal and clear-on-match
// Assumes: all inputs come from logic on clk_i; tick from a prescaler
// Notes:   pwm counting sequences are not built, only their buffering
`timescale 1ns/1ps

// Behaviour
// RQ1 - counter compared against both compare values at all times
// RQ2 - a match sets its flag at the following timer tick
// RQ3 - enabled flag raises request; service or writing one clears it
// RQ4 - compare values buffered in pwm modes, direct in others
// RQ5 - access reaches buffer when buffering, active value otherwise
// RQ6 - force strobe acts on latch only, no flag, no counter change
// RQ7 - counter write blocks matches until the next timer tick
// RQ8 - latches keep their level across mode changes
// RQ9 - output action changes apply at once, unbuffered
// RQ10 - reset clears both output latches
// RQ11 - nonzero action puts latch on pin; direction from port bit
// RQ12 - action zero leaves the latch alone on a match
// RQ13 - mode field picks counting; actions never touch counting
// RQ14 - normal mode counts up and wraps from ff to 00
// RQ15 - normal mode sets overflow as counter becomes zero
// RQ16 - servicing the overflow request clears its flag
// RQ17 - clear-on-match mode clears counter the tick after matching A
// RQ18 - value A below count is missed until the counter wraps
// RQ19 - flag A set each time the top is reached
// RQ20 - toggle action inverts latch A on each match
// RQ21 - clear-on-match mode sets overflow on max to 00
// RQ22 - software sets latches up before enabling pin; avoids bad writes
// RQ23 - clock select zero stops the counter, access still works
// RQ24 - counter write beats count and clear in the same cycle
// RQ25 - max is ff, bottom 00, top depends on mode
// RQ26 - writing zero keeps flags; force bits read as zero
module t8c_timer
	import t8c_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// register port
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// timer clock enable from the prescaler
	input  wire logic       timer_tick_i,
	// interrupt requests, bit order overflow, A, B
	input  wire logic [2:0] irq_ack_i,
	output logic      [2:0] irq_o,
	// port pin logic, bit 0 unit A, bit 1 unit B
	input  wire logic [1:0] port_data_i,
	input  wire logic [1:0] output_pin_direction_bit_i,
	output logic      [1:0] pin_out_o,
	output logic      [1:0] pin_oe_o,
	output logic      [1:0] compare_output_o
);
	typedef struct packed {
		logic [2:0] waveform_mode_sel;
		logic [1:0] output_action_sel_a;
		logic [1:0] output_action_sel_b;
		logic [2:0] clock_source_sel;
		logic [2:0] flags;
		logic [2:0] irq_en;
		logic [7:0] rdata;
	} t8c_top_s;
	t8c_top_s st;
	t8c_top_s next_st;

	// decoded write strobe for one offset
	function automatic logic t8c_wsel(input logic       wr,
	                                  input logic [3:0] addr,
	                                  input logic [3:0] ofs);
		return wr && (addr == ofs);
	endfunction

	logic       wr_ctrl;
	logic       wr_clk;
	logic       wr_count;
	logic       wr_flags;
	logic       tick;
	logic       pwm;
	logic       clear_on_match;
	logic       wrap;
	logic       block;
	logic [7:0] count_value;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;

	t8c_unit_if ua ();
	t8c_unit_if ub ();

	////////////////////////////////////////////////////////////////////
	// decode and timer clock enable

	// write strobes per register
	assign wr_ctrl  = t8c_wsel(reg_wr_i, reg_addr_i, T8C_OFS_CTRL);
	assign wr_clk   = t8c_wsel(reg_wr_i, reg_addr_i, T8C_OFS_CLK);
	assign wr_count = t8c_wsel(reg_wr_i, reg_addr_i, T8C_OFS_COUNT);
	assign wr_flags = t8c_wsel(reg_wr_i, reg_addr_i, T8C_OFS_FLAGS);

	// a stopped source means no ticks, the register port still works
	assign tick = timer_tick_i && (st.clock_source_sel != T8C_CLK_STOP); // RQ23
	assign pwm  = t8c_is_pwm(st.waveform_mode_sel); // RQ4
	// only the mode field shapes counting
	// equality only: a top written below the count is passed until the wrap
	assign clear_on_match = (st.waveform_mode_sel == T8C_MODE_CLEAR_ON_MATCH)
		&& ua.hit; // RQ13 RQ17 RQ18 RQ25

	////////////////////////////////////////////////////////////////////
	// counter

	t8c_counter u_counter (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.tick_i  (tick),
		.clear_i (clear_on_match),
		.wr_i    (wr_count),
		.wdata_i (reg_wdata_i),
		.count_o (count_value),
		.block_o (block),
		.wrap_o  (wrap)
	);

	////////////////////////////////////////////////////////////////////
	// compare units

	// unit A feeds
	assign ua.count  = count_value;
	assign ua.tick   = tick;
	assign ua.block  = block;
	assign ua.pwm    = pwm;
	assign ua.action = st.output_action_sel_a; // RQ9
	assign ua.wr     = t8c_wsel(reg_wr_i, reg_addr_i, T8C_OFS_CMPA);
	assign ua.wdata  = reg_wdata_i;
	assign ua.frc    = wr_clk && reg_wdata_i[T8C_FRCA_BIT]; // RQ6

	// unit B feeds
	assign ub.count  = count_value;
	assign ub.tick   = tick;
	assign ub.block  = block;
	assign ub.pwm    = pwm;
	assign ub.action = st.output_action_sel_b; // RQ9
	assign ub.wr     = t8c_wsel(reg_wr_i, reg_addr_i, T8C_OFS_CMPB);
	assign ub.wdata  = reg_wdata_i;
	assign ub.frc    = wr_clk && reg_wdata_i[T8C_FRCB_BIT]; // RQ6

	t8c_cmp_unit u_unit_a (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.u      (ua)
	);

	t8c_cmp_unit u_unit_b (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.u      (ub)
	);

	////////////////////////////////////////////////////////////////////
	// flags and requests

	// hit is already a tick-timed event, so the flag lands one tick on
	assign flag_set = {ub.hit, ua.hit, wrap}; // RQ2 RQ15 RQ19 RQ21
	// service acknowledge or a one written clears; zero leaves alone
	assign flag_clr = (wr_flags ? reg_wdata_i[2:0] : 3'b000) | irq_ack_i; // RQ3 RQ16 RQ26
	assign irq_o    = st.flags & st.irq_en; // RQ3

	////////////////////////////////////////////////////////////////////
	// pins

	// latch overrides the port value only while an action is chosen
	always_comb
	begin
		pin_out_o[0] = (st.output_action_sel_a != T8C_ACT_NONE) ?
			ua.latch : port_data_i[0]; // RQ11
		pin_out_o[1] = (st.output_action_sel_b != T8C_ACT_NONE) ?
			ub.latch : port_data_i[1]; // RQ11
	end
	assign pin_oe_o         = output_pin_direction_bit_i; // RQ11
	assign compare_output_o = {ub.latch, ua.latch};
	assign reg_rdata_o      = st.rdata;

	////////////////////////////////////////////////////////////////////
	// register file next state

	always_comb
	begin
		next_st = st;
		if (wr_ctrl)
		begin
			// mode change leaves latches untouched
			next_st.waveform_mode_sel   = reg_wdata_i[T8C_MODE_LSB +: 3]; // RQ8
			next_st.output_action_sel_a = reg_wdata_i[T8C_ACTA_LSB +: 2];
			next_st.output_action_sel_b = reg_wdata_i[T8C_ACTB_LSB +: 2];
		end
		if (wr_clk)
			next_st.clock_source_sel = reg_wdata_i[T8C_CSEL_LSB +: 3];
		if (t8c_wsel(reg_wr_i, reg_addr_i, T8C_OFS_IRQEN))
			next_st.irq_en = reg_wdata_i[2:0];
		// set wins over a clear in the same cycle
		next_st.flags = (st.flags & ~flag_clr) | flag_set;
		// read data stand for one cycle only
		next_st.rdata = T8C_RST_BYTE;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				T8C_OFS_CTRL:  next_st.rdata = {st.output_action_sel_b,
					st.output_action_sel_a, 1'b0, st.waveform_mode_sel};
				T8C_OFS_CLK:   next_st.rdata = {5'h00, st.clock_source_sel}; // RQ26
				T8C_OFS_COUNT: next_st.rdata = count_value; // RQ23
				T8C_OFS_CMPA:  next_st.rdata = ua.rdata; // RQ5
				T8C_OFS_CMPB:  next_st.rdata = ub.rdata; // RQ5
				T8C_OFS_FLAGS: next_st.rdata = {5'h00, st.flags};
				T8C_OFS_IRQEN: next_st.rdata = {5'h00, st.irq_en};
				default:       next_st.rdata = T8C_RST_BYTE;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			st <= '0;
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_stop_holds_count: assert property ( // RQ23
		(st.clock_source_sel == T8C_CLK_STOP && !wr_count)
		|=> $stable(count_value))
		else $error("counter moved while stopped");

	a_write_wins_count: assert property ( // RQ24
		wr_count |=> count_value == $past(reg_wdata_i))
		else $error("counter write lost");

	a_match_sets_flag: assert property ( // RQ2
		(tick && ua.eq && !block && !irq_ack_i[T8C_FLG_A])
		|-> !st.flags[T8C_FLG_A] ##1 st.flags[T8C_FLG_A] or
		st.flags[T8C_FLG_A] ##1 st.flags[T8C_FLG_A])
		else $error("match flag A not set one cycle after tick");

	a_block_after_write: assert property ( // RQ7
		(wr_count ##1 (tick && !wr_count))
		|-> !ua.hit && !ub.hit)
		else $error("match not blocked after counter write");

	a_wrap_sets_ovf: assert property ( // RQ15
		(tick && count_value == T8C_COUNT_MAX && !wr_count)
		|=> st.flags[T8C_FLG_OVF] && count_value == T8C_COUNT_BOTTOM)
		else $error("overflow flag or wrap missing");

	a_clear_on_top: assert property ( // RQ17
		(st.waveform_mode_sel == T8C_MODE_CLEAR_ON_MATCH && tick
		 && ua.eq && !block && !wr_count)
		|=> count_value == T8C_COUNT_BOTTOM)
		else $error("counter not cleared at top");

	a_normal_counts_up: assert property ( // RQ14
		(st.waveform_mode_sel == T8C_MODE_NORMAL && tick && !wr_count)
		|=> count_value == 8'($past(count_value) + 8'h01))
		else $error("normal mode did not increment");

	a_zero_keeps_flag: assert property ( // RQ26
		(wr_flags && !reg_wdata_i[T8C_FLG_B] && st.flags[T8C_FLG_B]
		 && !irq_ack_i[T8C_FLG_B])
		|=> st.flags[T8C_FLG_B])
		else $error("flag B lost on zero write");

	a_pin_takes_latch: assert property ( // RQ11
		(st.output_action_sel_a != T8C_ACT_NONE) |-> pin_out_o[0] == ua.latch)
		else $error("pin A not driven by latch");

	a_force_toggles: assert property ( // RQ6
		(ua.frc && !pwm && !ua.hit && st.output_action_sel_a == T8C_ACT_TOGGLE
		 && !irq_ack_i[T8C_FLG_A] && !wr_flags && !wr_count)
		|=> ua.latch != $past(ua.latch)
		&& st.flags[T8C_FLG_A] == $past(st.flags[T8C_FLG_A])
		&& count_value == 8'($past(count_value) + {7'h00, $past(tick)}))
		else $error("force did not act on latch alone");

	a_none_keeps_latch: assert property ( // RQ12
		(st.output_action_sel_b == T8C_ACT_NONE) |=> $stable(ub.latch))
		else $error("latch B changed with no action");

	a_ack_clears_flag: assert property ( // RQ16
		(irq_ack_i[T8C_FLG_OVF] && !wrap) |=> !st.flags[T8C_FLG_OVF])
		else $error("overflow flag not cleared by service");

	a_match_b_flag: assert property ( // RQ1
		(tick && ub.eq && !block) |=> st.flags[T8C_FLG_B])
		else $error("match flag B not set after tick");

	a_ovf_held: assert property ( // RQ15
		(st.flags[T8C_FLG_OVF] && !irq_ack_i[T8C_FLG_OVF]
		 && !(wr_flags && reg_wdata_i[T8C_FLG_OVF]))
		|=> st.flags[T8C_FLG_OVF])
		else $error("overflow flag dropped on its own");

	a_one_clears_flag: assert property ( // RQ3
		(wr_flags && reg_wdata_i[T8C_FLG_A] && !ua.hit) |=> !st.flags[T8C_FLG_A])
		else $error("flag A not cleared by a written one");

	a_ctc_sets_top: assert property ( // RQ19
		(st.waveform_mode_sel == T8C_MODE_CLEAR_ON_MATCH && ua.hit && !wr_count)
		|=> st.flags[T8C_FLG_A] && count_value == T8C_COUNT_BOTTOM)
		else $error("top reached without flag A or clear");

	a_ctc_toggles_a: assert property ( // RQ20
		(st.waveform_mode_sel == T8C_MODE_CLEAR_ON_MATCH && ua.hit
		 && st.output_action_sel_a == T8C_ACT_TOGGLE)
		|=> ua.latch != $past(ua.latch))
		else $error("latch A did not toggle on match");

	a_ctc_wrap_ovf: assert property ( // RQ21
		(st.waveform_mode_sel == T8C_MODE_CLEAR_ON_MATCH && tick
		 && count_value == T8C_COUNT_MAX && !wr_count)
		|=> st.flags[T8C_FLG_OVF])
		else $error("overflow missing in clear-on-match mode");

	a_force_no_flag: assert property ( // RQ6
		(ub.frc && !ub.hit && !irq_ack_i[T8C_FLG_B])
		|=> st.flags[T8C_FLG_B] == $past(st.flags[T8C_FLG_B]))
		else $error("force on B touched its flag");

	a_pin_keeps_port: assert property ( // RQ11
		(st.output_action_sel_b == T8C_ACT_NONE) |-> pin_out_o[1] == port_data_i[1])
		else $error("pin B left the port value with no action");

	a_direct_access: assert property ( // RQ5
		(ua.wr && !pwm) |=> ua.rdata == $past(reg_wdata_i))
		else $error("compare A write not direct outside pwm");

	a_pwm_keeps_latch: assert property ( // RQ6
		pwm |=> $stable(ua.latch) && $stable(ub.latch))
		else $error("latch moved in a pwm mode");

	a_mode_keeps_latch: assert property ( // RQ8
		(wr_ctrl && !ua.hit) |=> $stable(ua.latch))
		else $error("latch A changed with the mode");
endmodule

// *** tb/t8c_core_model.sv ***
// Purpose: core and port stand-in: services requests, resolves pin levels
// Assumes: pins carry pull-ups when the direction bit leaves them undriven
// Notes:   one service pulse, then a quiet cycle so a flag is never served twice
`timescale 1ns/1ps
module t8c_core_model
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// service side
	input  wire logic       svc_en_i,
	input  wire logic [2:0] irq_i,
	output logic      [2:0] irq_ack_o,
	// pins
	input  wire logic [1:0] pin_out_i,
	input  wire logic [1:0] pin_oe_i,
	output logic      [1:0] pin_level_o
);
	// undriven pins float up to the pull-up level
	assign pin_level_o = (pin_out_i & pin_oe_i) | ~pin_oe_i;

	// serve the lowest pending request; the gap lets the flag drop first
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			irq_ack_o <= 3'h0;
		else if (svc_en_i && irq_ack_o == 3'h0)
			irq_ack_o <= irq_i & (~irq_i + 3'h1);
		else
			irq_ack_o <= 3'h0;
	end
endmodule

// *** tb/t8c_timer_tb_top.sv ***
// Purpose: self-checking bench for the timer compare block
// Assumes: register port answers reads one cycle later, never stalls
// Notes:   tick is driven as a level; each sampled high edge is one tick
`timescale 1ns/1ps
module t8c_timer_tb_top
	import t8c_pkg::*;
;
	logic       clk;
	logic       nrst;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       tick;
	logic [2:0] ack;
	logic [2:0] irq;
	logic [1:0] pdat;
	logic [1:0] pdir;
	logic [1:0] pout;
	logic [1:0] poe;
	logic [1:0] cout;
	logic [1:0] lvl;
	logic       svc;
	int         n_mismatch = 0;
	int         n_checks = 0;

	t8c_timer dut_u (.clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .timer_tick_i(tick),
		.irq_ack_i(ack), .irq_o(irq), .port_data_i(pdat),
		.output_pin_direction_bit_i(pdir), .pin_out_o(pout), .pin_oe_o(poe),
		.compare_output_o(cout));
	t8c_core_model core_u (.clk_i(clk), .nrst_i(nrst), .svc_en_i(svc), .irq_i(irq),
		.irq_ack_o(ack), .pin_out_i(pout), .pin_oe_i(poe), .pin_level_o(lvl));

	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write; the strobe drops an edge before the next access
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe, so sample there
	task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic ticks(input int n);
		@(posedge clk);
		tick <= 1'b1;
		repeat (n) @(posedge clk);
		tick <= 1'b0;
	endtask

	function automatic logic [7:0] ctrl(input logic [2:0] m, input logic [1:0] a,
	                                    input logic [1:0] b);
		return {b, a, 1'b0, m};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 7; i++)
			rreg(4'(i), T8C_RST_BYTE);
		wreg(4'hf, 8'hff);
		rreg(4'hf, 8'h00);
		chk({6'h0, cout}, 8'h00);
		chk({6'h0, pout}, {6'h0, pdat});
	endtask

	task automatic t_normal();
		wreg(T8C_OFS_CMPA, 8'h10);
		wreg(T8C_OFS_CMPB, 8'h11);
		wreg(T8C_OFS_CLK, 8'h01);
		wreg(T8C_OFS_COUNT, 8'h0f);
		ticks(1);
		rreg(T8C_OFS_FLAGS, 8'h00);
		ticks(1);
		rreg(T8C_OFS_FLAGS, 8'h02);
		ticks(1);
		rreg(T8C_OFS_FLAGS, 8'h06);
		wreg(T8C_OFS_COUNT, 8'hfe);
		ticks(1);
		rreg(T8C_OFS_FLAGS, 8'h06);
		ticks(1);
		rreg(T8C_OFS_COUNT, T8C_COUNT_BOTTOM);
		rreg(T8C_OFS_FLAGS, 8'h07);
	endtask

	task automatic t_flags();
		int i;
		wreg(T8C_OFS_FLAGS, 8'h00);
		rreg(T8C_OFS_FLAGS, 8'h07);
		wreg(T8C_OFS_FLAGS, 8'h04);
		rreg(T8C_OFS_FLAGS, 8'h03);
		wreg(T8C_OFS_IRQEN, 8'h03);
		#1;
		chk({5'h0, irq}, 8'h03);
		svc <= 1'b1;
		for (i = 0; i < 20 && irq !== 3'h0; i++)
			@(posedge clk);
		if (i == 20)
		begin
			n_mismatch++;
			$display("ERROR %0t request never serviced", $time);
			results();
		end
		svc <= 1'b0;
		rreg(T8C_OFS_FLAGS, 8'h00);
		wreg(T8C_OFS_IRQEN, 8'h00);
	endtask

	task automatic t_block();
		wreg(T8C_OFS_CLK, 8'h00);
		wreg(T8C_OFS_CMPA, 8'h40);
		wreg(T8C_OFS_COUNT, 8'h40);
		ticks(3);
		rreg(T8C_OFS_COUNT, 8'h40);
		wreg(T8C_OFS_CLK, 8'h01);
		ticks(1);
		rreg(T8C_OFS_COUNT, 8'h41);
		rreg(T8C_OFS_FLAGS, 8'h00);
		// write of the counter lands on a tick; the tick after it is blocked
		@(posedge clk);
		tick <= 1'b1;
		wreg(T8C_OFS_COUNT, 8'h40);
		@(posedge clk);
		tick <= 1'b0;
		rreg(T8C_OFS_COUNT, 8'h41);
		rreg(T8C_OFS_FLAGS, 8'h00);
	endtask

	task automatic t_ctc();
		wreg(T8C_OFS_CTRL, ctrl(T8C_MODE_CLEAR_ON_MATCH, T8C_ACT_TOGGLE, T8C_ACT_NONE));
		wreg(T8C_OFS_CMPA, 8'h03);
		wreg(T8C_OFS_CMPB, 8'h02);
		wreg(T8C_OFS_COUNT, 8'h00);
		ticks(4);
		rreg(T8C_OFS_COUNT, 8'h00);
		rreg(T8C_OFS_FLAGS, 8'h06);
		chk({6'h0, cout}, 8'h01);
		ticks(4);
		#1;
		chk({6'h0, cout}, 8'h00);
		// top written below the count: runs to max and wraps
		wreg(T8C_OFS_FLAGS, 8'h07);
		wreg(T8C_OFS_COUNT, 8'h10);
		ticks(240);
		rreg(T8C_OFS_COUNT, 8'h00);
		rreg(T8C_OFS_FLAGS, 8'h01);
		ticks(4);
		rreg(T8C_OFS_FLAGS, 8'h07);
	endtask

	task automatic t_force();
		// latches settle in the update of the write edge, so look just after it
		wreg(T8C_OFS_CTRL, ctrl(T8C_MODE_NORMAL, T8C_ACT_TOGGLE, T8C_ACT_NONE));
		#1;
		chk({6'h0, cout}, 8'h01);
		wreg(T8C_OFS_CLK, 8'h00);
		wreg(T8C_OFS_FLAGS, 8'h07);
		wreg(T8C_OFS_CLK, 8'h40);
		#1;
		chk({6'h0, cout}, 8'h00);
		rreg(T8C_OFS_FLAGS, 8'h00);
		rreg(T8C_OFS_COUNT, 8'h00);
		rreg(T8C_OFS_CLK, 8'h00);
		wreg(T8C_OFS_CTRL, ctrl(T8C_MODE_NORMAL, T8C_ACT_SET, T8C_ACT_SET));
		wreg(T8C_OFS_CLK, 8'hc0);
		#1;
		chk({6'h0, cout}, 8'h03);
		wreg(T8C_OFS_CTRL, ctrl(T8C_MODE_NORMAL, T8C_ACT_CLEAR, T8C_ACT_NONE));
		wreg(T8C_OFS_CLK, 8'h40);
		// latch set up before the pin turns to output
		@(posedge clk);
		pdir <= 2'b01;
		@(posedge clk);
		#1;
		chk({6'h0, cout}, 8'h02);
		chk({6'h0, pout}, 8'h00);
		chk({6'h0, poe}, 8'h01);
		chk({6'h0, lvl}, 8'h02);
	endtask

	// pwm mode 1 with the clock stopped: writes reach only the buffer
	task automatic t_buffer();
		wreg(T8C_OFS_CTRL, ctrl(3'h1, T8C_ACT_NONE, T8C_ACT_NONE));
		wreg(T8C_OFS_CMPA, 8'h20);
		rreg(T8C_OFS_CMPA, 8'h20);
		wreg(T8C_OFS_CTRL, ctrl(T8C_MODE_NORMAL, T8C_ACT_NONE, T8C_ACT_NONE));
		rreg(T8C_OFS_CMPA, 8'h03);
		chk({6'h0, cout}, 8'h02);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// reset, then the scenarios in order
	initial
	begin
		nrst = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		tick = 1'b0;
		pdat = 2'b00;
		pdir = 2'b00;
		svc = 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_normal();
		t_flags();
		t_block();
		t_ctc();
		t_force();
		t_buffer();
		results();
	end
endmodule
